//--- common/tfe_consts.vh
// Register map, field positions and reset values of the timer flag block
`ifndef TFE_CONSTS_VH
`define TFE_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses)
`define TFE_CTRL_OFS 8'h00
`define TFE_IEN_OFS 8'h04
`define TFE_STATUS_OFS 8'h08
`define TFE_EVGEN_OFS 8'h0c
`define TFE_CMP1_OFS 8'h10
`define TFE_CAP_BASE_OFS 8'h10
`define TFE_CNT_OFS 8'h20
`define TFE_RAW_OFS 8'h24
`define TFE_RAWCLR_OFS 8'h28
`define TFE_RAWEN_OFS 8'h2c

// ==========================================================
// Control register fields
`define TFE_CTRL_UPDATE_DISABLE 0
`define TFE_CTRL_URS 1
`define TFE_CTRL_CMS 2
`define TFE_CTRL_MOE 3
`define TFE_CTRL_MODE_LO 4

// ==========================================================
// Status register fields
`define TFE_ST_UPD 0
`define TFE_ST_CH_LO 1
`define TFE_ST_TRG 6
`define TFE_ST_BRK 7
`define TFE_ST_OVR_LO 9
`define TFE_ST_MASK 16'h1edf

// ==========================================================
// Event generation fields
`define TFE_EG_UG 0
`define TFE_EG_TG 6
`define TFE_EG_BG 7

// ==========================================================
// Reset values and raw event count
`define TFE_CTRL_RST 16'h0008
`define TFE_NUM_EV 4

`endif

//--- core/tfe_update_src.v
// Update event source qualification
`timescale 1ns/10ps
module tfe_update_src (
	input wire update_disable_in,
	input wire update_request_source_in,
	input wire rep_wrap_in,
	input wire sw_generate_in,
	input wire sw_reinit_in,
	input wire trig_reinit_in,
	output wire update_event_out
);
	wire any_req;
	assign any_req = sw_generate_in | sw_reinit_in | trig_reinit_in;
	assign update_event_out = ~update_disable_in &
		(rep_wrap_in | (~update_request_source_in & any_req));
endmodule

//--- core/tfe_chan_flag.v
// One compare/capture channel flag with its overrun flag
`timescale 1ns/10ps
module tfe_chan_flag (
	input wire mclk_in,
	input wire arst_n_in,
	input wire input_mode_in,
	input wire match_in,
	input wire centre_in,
	input wire capture_in,
	input wire cap_read_in,
	input wire sw_clr_in,
	input wire ovr_clr_in,
	output reg flag_q_out,
	output reg ovr_q_out
);
	wire set_ev;
	assign set_ev = input_mode_in ? capture_in : (match_in & ~centre_in);
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flag_q_out <= 1'b0;
			ovr_q_out <= 1'b0;
		end else begin
			// Set wins over a clear in the same cycle
			if (set_ev)
				flag_q_out <= 1'b1;
			else if (sw_clr_in | (input_mode_in & cap_read_in))
				flag_q_out <= 1'b0;
			if (input_mode_in & capture_in & flag_q_out)
				ovr_q_out <= 1'b1;
			else if (ovr_clr_in)
				ovr_q_out <= 1'b0;
		end
	end
endmodule

//--- core/tfe_top.v
// Timer status flags, event generation and Wishbone register slave
`timescale 1ns/10ps
`include "tfe_consts.vh"
module tfe_top #(
	parameter NUM_CH = 4
) (
	input wire mclk_in,
	input wire arst_n_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [7:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	input wire [15:0] core_counter_in,
	input wire [NUM_CH-1:0] capture_in,
	input wire rep_wrap_in,
	input wire sw_reinit_in,
	input wire trig_reinit_in,
	input wire trig_input_in,
	input wire brk_input_in,
	output wire main_output_enable_out,
	output reg update_pulse_out,
	output reg trig_pulse_out,
	output reg brk_pulse_out,
	output wire irq_out
);
	// ==========================================================
	// Registers
	reg [15:0] ctrl_q;
	reg [15:0] ien_q;
	reg [15:0] cmp_q [0:NUM_CH-1];
	reg [15:0] cap_q [0:NUM_CH-1];
	reg update_flag_q;
	reg trigger_flag_q;
	reg break_flag_q;
	reg break_generate_q;
	reg [3:0] raw_q;
	reg [3:0] raw_en_q;
	reg [31:0] rd_d;
	wire [NUM_CH-1:0] chan_flag;
	wire [NUM_CH-1:0] chan_ovr;
	wire [15:0] status;
	wire acc;
	wire wr;
	wire wr_lo;
	wire st_wr;
	wire eg_wr;
	wire update_event;
	wire trig_event;
	wire brk_event;
	wire [3:0] raw_ev;

	// ==========================================================
	// Bus decode
	assign acc = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign wr = acc & wb_we_in;
	assign wr_lo = wr & wb_sel_in[0] & wb_sel_in[1];
	assign st_wr = wr_lo && (wb_adr_in == `TFE_STATUS_OFS);
	assign eg_wr = wr_lo && (wb_adr_in == `TFE_EVGEN_OFS);

	// Event generation bits: writing 0 generates no event, but clears the bit 7 readback
	assign trig_event = (eg_wr & wb_dat_in[`TFE_EG_TG]) | trig_input_in;
	assign brk_event = (eg_wr & wb_dat_in[`TFE_EG_BG]) | brk_input_in;

	tfe_update_src u_upd (
		.update_disable_in(ctrl_q[`TFE_CTRL_UPDATE_DISABLE]),
		.update_request_source_in(ctrl_q[`TFE_CTRL_URS]),
		.rep_wrap_in(rep_wrap_in),
		.sw_generate_in(eg_wr & wb_dat_in[`TFE_EG_UG]),
		.sw_reinit_in(sw_reinit_in),
		.trig_reinit_in(trig_reinit_in),
		.update_event_out(update_event)
	);

	// ==========================================================
	// Channel flags
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
			tfe_chan_flag u_ch (
				.mclk_in(mclk_in),
				.arst_n_in(arst_n_in),
				.input_mode_in(ctrl_q[`TFE_CTRL_MODE_LO + g]),
				.match_in(core_counter_in == cmp_q[g]),
				.centre_in(ctrl_q[`TFE_CTRL_CMS]),
				.capture_in(capture_in[g]),
				.cap_read_in(acc && !wb_we_in && (wb_adr_in == `TFE_CAP_BASE_OFS + 8'h04 * g + 8'h20)),
				.sw_clr_in(st_wr & ~wb_dat_in[`TFE_ST_CH_LO + g]),
				.ovr_clr_in(st_wr & ~wb_dat_in[`TFE_ST_OVR_LO + g]),
				.flag_q_out(chan_flag[g]),
				.ovr_q_out(chan_ovr[g])
			);
			always @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					cmp_q[g] <= 16'h0000;
					cap_q[g] <= 16'h0000;
				end else begin
					if (wr_lo && (wb_adr_in == `TFE_CMP1_OFS + 8'h04 * g))
						cmp_q[g] <= wb_dat_in[15:0];
					if (ctrl_q[`TFE_CTRL_MODE_LO + g] & capture_in[g])
						cap_q[g] <= core_counter_in;
				end
			end
		end
	endgenerate

	// Reserved bits read zero
	assign status = {3'h0, chan_ovr, 1'b0, break_flag_q, trigger_flag_q, 1'b0, chan_flag, update_flag_q};
	assign main_output_enable_out = ctrl_q[`TFE_CTRL_MOE];

	// ==========================================================
	// Flags and control
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_q <= `TFE_CTRL_RST;
			ien_q <= 16'h0000;
			update_flag_q <= 1'b0;
			trigger_flag_q <= 1'b0;
			break_flag_q <= 1'b0;
			break_generate_q <= 1'b0;
			update_pulse_out <= 1'b0;
			trig_pulse_out <= 1'b0;
			brk_pulse_out <= 1'b0;
		end else begin
			update_pulse_out <= update_event;
			trig_pulse_out <= trig_event;
			brk_pulse_out <= brk_event;
			if (wr_lo && (wb_adr_in == `TFE_CTRL_OFS))
				ctrl_q <= wb_dat_in[15:0];
			if (brk_event)
				ctrl_q[`TFE_CTRL_MOE] <= 1'b0;
			if (wr_lo && (wb_adr_in == `TFE_IEN_OFS))
				ien_q <= wb_dat_in[15:0];
			if (eg_wr)
				break_generate_q <= wb_dat_in[`TFE_EG_BG];
			if (update_event)
				update_flag_q <= 1'b1;
			else if (st_wr & ~wb_dat_in[`TFE_ST_UPD])
				update_flag_q <= 1'b0;
			if (trig_event)
				trigger_flag_q <= 1'b1;
			else if (st_wr & ~wb_dat_in[`TFE_ST_TRG])
				trigger_flag_q <= 1'b0;
			if (brk_event)
				break_flag_q <= 1'b1;
			else if (st_wr & ~wb_dat_in[`TFE_ST_BRK])
				break_flag_q <= 1'b0;
		end
	end

	// ==========================================================
	// Raw event status, clear and enable
	assign raw_ev = {brk_event, trig_event, |(capture_in), update_event};
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			raw_q <= 4'h0;
			raw_en_q <= 4'h0;
		end else begin
			raw_q <= raw_ev | (raw_q & ~((wr && (wb_adr_in == `TFE_RAWCLR_OFS)) ? wb_dat_in[3:0] : 4'h0));
			if (wr && (wb_adr_in == `TFE_RAWEN_OFS))
				raw_en_q <= wb_dat_in[3:0];
		end
	end
	assign irq_out = |(status & ien_q) | |(raw_q & raw_en_q);

	// ==========================================================
	// Read mux and ack (one wait-free cycle)
	always @* begin
		rd_d = 32'h0000_0000;
		if (wb_adr_in == `TFE_CTRL_OFS)
			rd_d[15:0] = ctrl_q;
		else if (wb_adr_in == `TFE_IEN_OFS)
			rd_d[15:0] = ien_q;
		else if (wb_adr_in == `TFE_STATUS_OFS)
			rd_d[15:0] = status;
		else if (wb_adr_in == `TFE_EVGEN_OFS)
			rd_d[`TFE_EG_BG] = break_generate_q;
		else if (wb_adr_in == `TFE_CNT_OFS)
			rd_d[15:0] = core_counter_in;
		else if (wb_adr_in == `TFE_RAW_OFS)
			rd_d[3:0] = raw_q;
		else if (wb_adr_in == `TFE_RAWEN_OFS)
			rd_d[3:0] = raw_en_q;
		else if (wb_adr_in >= `TFE_CMP1_OFS && wb_adr_in < `TFE_CNT_OFS)
			rd_d[15:0] = cmp_q[wb_adr_in[3:2]];
		else if (wb_adr_in >= 8'h30 && wb_adr_in < 8'h40)
			rd_d[15:0] = cap_q[wb_adr_in[3:2]];
	end
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= acc;
			if (acc && !wb_we_in)
				wb_dat_out <= rd_d;
		end
	end
endmodule

//--- verif/tfe_top_sva.sv
// Port-level assertions for the timer flag block
`timescale 1ns/10ps
module tfe_top_sva (
	input wire mclk_in,
	input wire arst_n_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [7:0] wb_adr_in,
	input wire [31:0] wb_dat_in,
	input wire [31:0] wb_dat_out,
	input wire wb_ack_out,
	input wire rep_wrap_in,
	input wire sw_reinit_in,
	input wire trig_reinit_in,
	input wire trig_input_in,
	input wire main_output_enable_out,
	input wire update_pulse_out,
	input wire trig_pulse_out,
	input wire brk_pulse_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	// ==========================
	// Recent causes of the event pulses
	logic [3:0] uh_q;
	logic [3:0] th_q;
	wire rd = wb_cyc_in && wb_stb_in && !wb_we_in && wb_ack_out;
	wire eg_wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_adr_in == 8'h0c;
	always @(posedge mclk_in or negedge arst_n_in)
		if (!arst_n_in) begin
			uh_q <= 4'h0;
			th_q <= 4'h0;
		end else begin
			uh_q <= {uh_q[2:0], rep_wrap_in | sw_reinit_in | trig_reinit_in | (eg_wr & wb_dat_in[0])};
			th_q <= {th_q[2:0], trig_input_in | (eg_wr & wb_dat_in[6])};
		end
	// ==========================
	// Properties
	a_ack_late: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
	a_ack_once: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
	a_unmapped_zero: assert property (rd && wb_adr_in == 8'h40 |-> wb_dat_out == 32'h0) else $error("unmapped");
	a_status_rsvd: assert property (rd && wb_adr_in == 8'h08 |-> wb_dat_out[31:13] == 19'h0 && !wb_dat_out[8])
		else $error("status reserved");
	a_evgen_self: assert property (rd && wb_adr_in == 8'h0c |-> wb_dat_out[6:0] == 7'h0) else $error("evgen");
	a_brk_moe: assert property (brk_pulse_out |-> ##[0:1] !main_output_enable_out) else $error("moe kept");
	a_upd_cause: assert property (update_pulse_out |-> |uh_q) else $error("update no cause");
	a_trig_cause: assert property (trig_pulse_out |-> |th_q) else $error("trigger no cause");
endmodule

//--- verif/tb_tfe_top.sv
// Self-checking bench for the timer flag and event block
`timescale 1ns/10ps
module tb_tfe_top;
	logic mclk_in, arst_n_in, wb_cyc_in, wb_we_in, rep_wrap_in, sw_reinit_in, trig_reinit_in;
	logic trig_input_in, brk_input_in, wb_ack_out, main_output_enable_out, irq_out;
	logic update_pulse_out, trig_pulse_out, brk_pulse_out;
	logic [7:0] wb_adr_in;
	logic [31:0] wb_dat_in, wb_dat_out, rdat;
	logic [15:0] core_counter_in;
	logic [3:0] capture_in;
	logic [6:0] pv;
	int mismatches, check_count, i;
	// Control, event code, expected status
	logic [35:0] rows [15] = '{36'h0008_0_0001, 36'h0009_0_0000, 36'h000a_0_0001, 36'h0008_1_0001,
		36'h000a_1_0000, 36'h0008_2_0001, 36'h000a_2_0000, 36'h0008_6_0002, 36'h000c_6_0000, 36'h0018_5_0002,
		36'h0008_7_0001, 36'h000a_7_0000, 36'h0008_8_0040, 36'h0008_3_0040, 36'h0008_4_0080};
	assign {capture_in, brk_input_in, trig_input_in, trig_reinit_in, sw_reinit_in, rep_wrap_in} = {3'h0, pv[5:0]};
	// Compare 1 holds 0x55, so the idle value never matches
	assign core_counter_in = pv[6] ? 16'h0055 : 16'h7fff;
	tfe_top uut (.mclk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in(wb_cyc_in), .wb_we_in, .wb_adr_in, .wb_sel_in(4'hf),
		.wb_dat_in, .wb_dat_out, .wb_ack_out, .core_counter_in, .capture_in, .rep_wrap_in, .sw_reinit_in,
		.trig_reinit_in, .trig_input_in, .brk_input_in, .main_output_enable_out, .update_pulse_out,
		.trig_pulse_out, .brk_pulse_out, .irq_out);
	initial begin
		mclk_in = 0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input [31:0] e, input [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// Ack and read data are taken at the rising edge, before that edge's updates land
	task automatic bus(input w, input [7:0] a, input [31:0] d);
		int n;
		@(posedge mclk_in);
		wb_cyc_in <= 1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			end_of_test();
		end
		rdat = wb_dat_out;
		wb_cyc_in <= 0;
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		bus(1, a, d);
	endtask
	task automatic rc(input string nm, input [7:0] a, input [31:0] e);
		bus(0, a, 0);
		chk(nm, e, rdat);
	endtask
	task automatic ev(input [3:0] e);
		if (e > 6)
			wr(8'h0c, 32'h1 << (e == 7 ? 0 : e - 2));
		else begin
			@(posedge mclk_in);
			pv <= 7'h1 << e;
			@(posedge mclk_in);
			pv <= 0;
		end
		repeat (3) @(posedge mclk_in);
	endtask
	initial begin
		{arst_n_in, wb_cyc_in, wb_we_in, wb_adr_in, wb_dat_in, pv} = 0;
		repeat (5) @(posedge mclk_in);
		arst_n_in <= 1;
		chk("moe", 1, main_output_enable_out);
		rc("ctrl", 8'h00, 32'h8);
		rc("status", 8'h08, 0);
		wr(8'h10, 32'h55);
		for (i = 0; i < 15; i++) begin
			wr(8'h00, rows[i][35:20]);
			wr(8'h08, 0);
			ev(rows[i][19:16]);
			rc("row", 8'h08, rows[i][15:0]);
		end
		wr(8'h00, 32'h8);
		wr(8'h08, 0);
		ev(6);
		wr(8'h08, 32'hffff);
		rc("keep", 8'h08, 32'h2);
		wr(8'h00, 32'h18);
		wr(8'h08, 0);
		ev(5);
		ev(5);
		rc("ovr", 8'h08, 32'h202);
		rc("cap", 8'h30, 32'h7fff);
		rc("rdclr", 8'h08, 32'h200);
		wr(8'h08, 0);
		rc("ovrclr", 8'h08, 0);
		wr(8'h00, 32'h8);
		wr(8'h04, 32'h80);
		wr(8'h0c, 32'h80);
		chk("brkp", 1, brk_pulse_out);
		rc("brk", 8'h08, 32'h80);
		chk("moe", 0, main_output_enable_out);
		chk("irq", 1, irq_out);
		rc("bg", 8'h0c, 32'h80);
		wr(8'h0c, 0);
		wr(8'h08, 0);
		chk("irq", 0, irq_out);
		rc("bgclr", 8'h0c, 0);
		wr(8'h04, 0);
		ev(8);
		chk("mask", 0, irq_out);
		wr(8'h04, 32'h40);
		chk("irq", 1, irq_out);
		wr(8'h0c, 32'h41);
		chk("trgp", 1, trig_pulse_out);
		chk("updp", 1, update_pulse_out);
		rc("none", 8'h40, 0);
		@(posedge mclk_in);
		arst_n_in <= 0;
		@(negedge mclk_in);
		chk("moe", 1, main_output_enable_out);
		chk("irq", 0, irq_out);
		@(posedge mclk_in);
		arst_n_in <= 1;
		rc("status", 8'h08, 0);
		end_of_test();
	end
endmodule
bind tfe_top tfe_top_sva sva_i (.mclk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in,
	.wb_dat_out, .wb_ack_out, .rep_wrap_in, .sw_reinit_in, .trig_reinit_in, .trig_input_in,
	.main_output_enable_out, .update_pulse_out, .trig_pulse_out, .brk_pulse_out);
